// File: hdl/ibx_exec.sv
// Decoder and executor for increment, bit and carry branches, indirect jump
// Behaviour
// - Opcode 00001rrr increments selected working register; one byte, one cycle.
// - Opcode 00000101 plus address increments direct data byte; two bytes.
// - Opcode 00100000 steps PC by 3, branches when addressed bit is one.
// - Opcode 00010000 like bit-one branch, also clears the bit when taken.
// - Opcode 00110000 steps PC by 3, branches when addressed bit is zero.
// - Opcode 01000000 steps PC by 2, branches when carry is one.
// - Opcode 01010000 steps PC by 2, branches when carry is zero.
// - Branch target is offset added to PC already past the instruction.
// - Opcode 01110011 loads PC with accumulator plus data pointer, operands kept.
// - Data pointer is handled as one 16-bit quantity.
`timescale 1ns/1ps
module ibx_exec (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic codeValid,
    input wire logic [ibx_pkg::DATA_W-1:0] codeByte,
    output logic codeTake,
    output logic [ibx_pkg::PC_W-1:0] progCounter,
    input wire logic [ibx_pkg::DATA_W-1:0] accum,
    input wire logic [ibx_pkg::PC_W-1:0] dataPointer16,
    input wire logic carryFlag,
    output logic [2:0] workingRegisterSel,
    input wire logic [ibx_pkg::DATA_W-1:0] regRdData,
    output logic regWrEn,
    output logic [ibx_pkg::DATA_W-1:0] regWrData,
    output logic [ibx_pkg::DATA_W-1:0] dataAddr,
    input wire logic [ibx_pkg::DATA_W-1:0] dataRdData,
    output logic dataWrEn,
    output logic [ibx_pkg::DATA_W-1:0] dataWrData,
    output logic [ibx_pkg::DATA_W-1:0] bitAddr,
    input wire logic bitRdData,
    output logic bitClrEn,
    output logic unknownOp
);
    import ibx_pkg::*;

    ibx_state_t state_ff;
    logic [DATA_W-1:0] opcode_ff;
    logic [DATA_W-1:0] addr_ff;
    logic [DATA_W-1:0] offs_ff;
    logic [PC_W-1:0] pc_ff;
    logic [PC_W-1:0] relTarget;
    logic [PC_W-1:0] indTarget;
    logic isIncReg;
    logic isBitOp;
    logic isCarryOp;
    logic isKnown;
    logic takeBranch;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    assign isIncReg = (codeByte[7:3] == OP_INC_REG_HI);
    assign isBitOp = (opcode_ff == OP_BRANCH_BIT_ONE) || (opcode_ff == OP_BRANCH_BIT_ZERO)
        || (opcode_ff == OP_BRANCH_BIT_ONE_AND_CLEAR);
    assign isCarryOp = (opcode_ff == OP_BRANCH_CARRY_ONE)
        || (opcode_ff == OP_BRANCH_CARRY_ZERO);
    assign isKnown = isIncReg || (codeByte == OP_INC_DIR) || (codeByte == OP_INDIRECT_JUMP)
        || (codeByte == OP_BRANCH_BIT_ONE) || (codeByte == OP_BRANCH_BIT_ZERO)
        || (codeByte == OP_BRANCH_BIT_ONE_AND_CLEAR) || (codeByte == OP_BRANCH_CARRY_ONE)
        || (codeByte == OP_BRANCH_CARRY_ZERO);

    always_comb begin
        takeBranch = 1'b0;
        case (opcode_ff)
            OP_BRANCH_BIT_ONE: takeBranch = bitRdData;
            OP_BRANCH_BIT_ONE_AND_CLEAR: takeBranch = bitRdData;
            OP_BRANCH_BIT_ZERO: takeBranch = !bitRdData;
            OP_BRANCH_CARRY_ONE: takeBranch = carryFlag;
            OP_BRANCH_CARRY_ZERO: takeBranch = !carryFlag;
            default: takeBranch = 1'b0;
        endcase
    end

    ibx_target_calc u_target (
        .nextPc(pc_ff),
        .relOffset(offs_ff),
        .accum(accum),
        .dataPointer16(dataPointer16),
        .relTarget(relTarget),
        .indTarget(indTarget)
    );

    // ----------------------------------------
    // Fetch handshake and memory strobes
    // ----------------------------------------
    assign codeTake = codeValid && ((state_ff == S_FETCH) || (state_ff == S_ADDR)
        || (state_ff == S_OFFS));
    assign progCounter = pc_ff;
    assign workingRegisterSel = codeByte[2:0];
    assign regWrEn = (state_ff == S_FETCH) && codeValid && isIncReg;
    assign regWrData = regRdData + ONE_BYTE;
    assign dataAddr = codeByte;
    assign dataWrEn = (state_ff == S_ADDR) && codeValid && (opcode_ff == OP_INC_DIR);
    assign dataWrData = dataRdData + ONE_BYTE;
    assign bitAddr = addr_ff;
    assign bitClrEn = (state_ff == S_EXEC) && (opcode_ff == OP_BRANCH_BIT_ONE_AND_CLEAR)
        && bitRdData;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= S_FETCH;
            opcode_ff <= 8'h00;
            addr_ff <= 8'h00;
            offs_ff <= 8'h00;
            unknownOp <= 1'b0;
        end else begin
            unknownOp <= 1'b0;
            case (state_ff)
                S_FETCH: begin
                    if (codeValid) begin
                        opcode_ff <= codeByte;
                        unknownOp <= !isKnown;
                        if (codeByte == OP_INC_DIR || codeByte == OP_BRANCH_BIT_ONE
                            || codeByte == OP_BRANCH_BIT_ZERO
                            || codeByte == OP_BRANCH_BIT_ONE_AND_CLEAR) begin
                            state_ff <= S_ADDR;
                        end else if (codeByte == OP_BRANCH_CARRY_ONE
                            || codeByte == OP_BRANCH_CARRY_ZERO) begin
                            state_ff <= S_OFFS;
                        end else if (codeByte == OP_INDIRECT_JUMP) begin
                            state_ff <= S_EXEC;
                        end
                    end
                end
                S_ADDR: begin
                    if (codeValid) begin
                        addr_ff <= codeByte;
                        state_ff <= isBitOp ? S_OFFS : S_FETCH;
                    end
                end
                S_OFFS: begin
                    if (codeValid) begin
                        offs_ff <= codeByte;
                        state_ff <= S_EXEC;
                    end
                end
                S_EXEC: state_ff <= S_FETCH;
                default: state_ff <= S_FETCH;
            endcase
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pc_ff <= PC_RESET;
        end else if (codeTake) begin
            pc_ff <= pc_ff + PC_STEP1;
        end else if (state_ff == S_EXEC) begin
            if (opcode_ff == OP_INDIRECT_JUMP) begin
                pc_ff <= indTarget;
            end else if (takeBranch) begin
                pc_ff <= relTarget;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    inc_reg_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_FETCH && codeValid && codeByte[7:3] == OP_INC_REG_HI)
        |-> regWrEn && regWrData == regRdData + ONE_BYTE ##1 state_ff == S_FETCH)
        else $error("register increment wrong");
    inc_dir_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_FETCH && codeValid && codeByte == OP_INC_DIR)
        ##1 (codeValid && state_ff == S_ADDR) |-> dataWrEn ##1 state_ff == S_FETCH)
        else $error("direct increment wrong");
    bit_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_BIT_ONE)
        |=> pc_ff == ($past(bitRdData) ? $past(relTarget) : $past(pc_ff)))
        else $error("bit one branch wrong");
    bit_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_BIT_ONE_AND_CLEAR)
        |-> bitClrEn == bitRdData)
        else $error("bit clear wrong");
    bit_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_BIT_ZERO && bitRdData)
        |=> pc_ff == $past(pc_ff))
        else $error("bit zero branch wrong");
    carry_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_CARRY_ONE && carryFlag)
        |=> pc_ff == $past(relTarget))
        else $error("carry one branch wrong");
    carry_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_CARRY_ZERO && carryFlag)
        |=> pc_ff == $past(pc_ff))
        else $error("carry zero branch wrong");
    rel_target_a: assert property (@(posedge ref_clk) disable iff (rst)
        relTarget == pc_ff + {{(PC_W-DATA_W){offs_ff[DATA_W-1]}}, offs_ff})
        else $error("relative target wrong");
    ind_jump_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_FETCH && codeValid && codeByte == OP_INDIRECT_JUMP)
        |=> state_ff == S_EXEC
        ##1 pc_ff == $past(dataPointer16) + {{(PC_W-DATA_W){1'b0}}, $past(accum)})
        else $error("indirect jump wrong");
    bit_zero_take_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_BIT_ZERO && !bitRdData)
        |=> pc_ff == $past(relTarget))
        else $error("bit zero taken branch wrong");
    carry_one_skip_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_CARRY_ONE && !carryFlag)
        |=> pc_ff == $past(pc_ff))
        else $error("carry one skip wrong");
    carry_zero_take_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC && opcode_ff == OP_BRANCH_CARRY_ZERO && !carryFlag)
        |=> pc_ff == $past(relTarget))
        else $error("carry zero taken branch wrong");
    exec_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_EXEC)
        |-> !codeTake && !regWrEn && !dataWrEn)
        else $error("fetch during execute");
    bit_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
        (state_ff == S_ADDR && codeValid && isBitOp)
        |=> bitAddr == $past(codeByte) && state_ff == S_OFFS)
        else $error("bit address order wrong");
endmodule

// File: hdl/ibx_pkg.sv
// Package of opcodes, states and widths for the increment and branch executor
package ibx_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam logic [4:0] OP_INC_REG_HI = 5'h01;
    localparam logic [7:0] OP_INC_DIR = 8'h05;
    localparam logic [7:0] OP_BRANCH_BIT_ONE = 8'h20;
    localparam logic [7:0] OP_BRANCH_BIT_ONE_AND_CLEAR = 8'h10;
    localparam logic [7:0] OP_BRANCH_BIT_ZERO = 8'h30;
    localparam logic [7:0] OP_BRANCH_CARRY_ONE = 8'h40;
    localparam logic [7:0] OP_BRANCH_CARRY_ZERO = 8'h50;
    localparam logic [7:0] OP_INDIRECT_JUMP = 8'h73;
    localparam logic [15:0] PC_STEP1 = 16'h0001;
    localparam logic [15:0] PC_STEP2 = 16'h0002;
    localparam logic [15:0] PC_STEP3 = 16'h0003;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] ONE_BYTE = 8'h01;

    typedef enum logic [2:0] {
        S_FETCH = 3'b000,
        S_ADDR = 3'b001,
        S_OFFS = 3'b010,
        S_EXEC = 3'b011,
        S_DONE = 3'b100
    } ibx_state_t;
endpackage

// File: hdl/ibx_target_calc.sv
// Branch target adder for relative and indirect jumps
`timescale 1ns/1ps
module ibx_target_calc (
    input wire logic [ibx_pkg::PC_W-1:0] nextPc,
    input wire logic [ibx_pkg::DATA_W-1:0] relOffset,
    input wire logic [ibx_pkg::DATA_W-1:0] accum,
    input wire logic [ibx_pkg::PC_W-1:0] dataPointer16,
    output logic [ibx_pkg::PC_W-1:0] relTarget,
    output logic [ibx_pkg::PC_W-1:0] indTarget
);
    import ibx_pkg::*;
    // Offset sign extended before the add
    assign relTarget = nextPc + {{(PC_W-DATA_W){relOffset[DATA_W-1]}}, relOffset};
    // Accumulator zero extended onto the full pointer
    assign indTarget = dataPointer16 + {{(PC_W-DATA_W){1'b0}}, accum};
endmodule

// File: verification/ibx_mem_model.sv
// Program, register, data and bit memory facing the executor
`timescale 1ns/1ps
module ibx_mem_model (
    input wire logic ref_clk,
    input wire logic [ibx_pkg::PC_W-1:0] progCounter,
    output logic codeValid,
    output logic [ibx_pkg::DATA_W-1:0] codeByte,
    input wire logic [2:0] workingRegisterSel,
    output logic [ibx_pkg::DATA_W-1:0] regRdData,
    input wire logic regWrEn,
    input wire logic [ibx_pkg::DATA_W-1:0] regWrData,
    input wire logic [ibx_pkg::DATA_W-1:0] dataAddr,
    output logic [ibx_pkg::DATA_W-1:0] dataRdData,
    input wire logic dataWrEn,
    input wire logic [ibx_pkg::DATA_W-1:0] dataWrData,
    input wire logic [ibx_pkg::DATA_W-1:0] bitAddr,
    output logic bitRdData,
    input wire logic bitClrEn
);
    import ibx_pkg::*;
    logic [7:0] code [65536];
    logic loaded [65536];
    logic [7:0] regs [8];
    logic [7:0] data [256];
    logic bits [256];
    logic [7:0] junk_ff = 8'h5a;
    initial for (int i = 0; i < 65536; i++) loaded[i] = 1'b0;
    // Unloaded code reads as a moving pattern
    assign codeValid = loaded[progCounter];
    assign codeByte = codeValid ? code[progCounter] : junk_ff;
    assign regRdData = regs[workingRegisterSel];
    assign dataRdData = data[dataAddr];
    assign bitRdData = bits[bitAddr];
    always @(posedge ref_clk) begin
        junk_ff <= junk_ff + 8'h35;
        if (regWrEn) regs[workingRegisterSel] <= regWrData;
        if (dataWrEn) data[dataAddr] <= dataWrData;
        if (bitClrEn) bits[bitAddr] <= 1'b0;
    end
endmodule

// File: verification/incr_branch_exec_subset_tb_top.sv
// Self-checking bench for the increment and branch executor
`timescale 1ns/1ps
module incr_branch_exec_subset_tb_top;
    import ibx_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic carryFlag = 1'b0;
    logic [7:0] accum = 8'h00;
    logic [15:0] dataPointer16 = 16'h0000;
    logic codeValid, codeTake, regWrEn, dataWrEn, bitRdData, bitClrEn, unknownOp;
    logic [7:0] codeByte, regRdData, regWrData, dataAddr, dataRdData, dataWrData, bitAddr;
    logic [15:0] progCounter;
    logic [2:0] workingRegisterSel;
    int err_count = 0;
    int samples_checked = 0;
    ibx_exec dut (
        .ref_clk(ref_clk), .rst(rst), .codeValid(codeValid), .codeByte(codeByte),
        .codeTake(codeTake), .progCounter(progCounter), .accum(accum),
        .dataPointer16(dataPointer16), .carryFlag(carryFlag),
        .workingRegisterSel(workingRegisterSel), .regRdData(regRdData), .regWrEn(regWrEn),
        .regWrData(regWrData), .dataAddr(dataAddr), .dataRdData(dataRdData),
        .dataWrEn(dataWrEn), .dataWrData(dataWrData), .bitAddr(bitAddr),
        .bitRdData(bitRdData), .bitClrEn(bitClrEn), .unknownOp(unknownOp)
    );
    ibx_mem_model mem (
        .ref_clk(ref_clk), .progCounter(progCounter), .codeValid(codeValid),
        .codeByte(codeByte), .workingRegisterSel(workingRegisterSel), .regRdData(regRdData),
        .regWrEn(regWrEn), .regWrData(regWrData), .dataAddr(dataAddr),
        .dataRdData(dataRdData), .dataWrEn(dataWrEn), .dataWrData(dataWrData),
        .bitAddr(bitAddr), .bitRdData(bitRdData), .bitClrEn(bitClrEn)
    );
    initial forever #20 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bytes offered gap idle cycles apart, so the decoder also waits between them
    task automatic run(input logic [23:0] b, input int n, input logic [15:0] e,
        input int gap);
        logic [15:0] p;
        p = progCounter;
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (gap) @(posedge ref_clk);
            @(posedge ref_clk);
            mem.code[16'(p + i)] <= b[23 - 8 * i -: 8];
            mem.loaded[16'(p + i)] <= 1'b1;
        end
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < n; i++) mem.loaded[16'(p + i)] <= 1'b0;
        chk(progCounter, e);
    endtask
    task automatic incRegAll();
        for (int r = 0; r < 8; r++) begin
            mem.regs[r] <= 8'hf9 + 8'(r);
            run({OP_INC_REG_HI, 3'(r), 16'h0}, 1, progCounter + PC_STEP1, 0);
            chk({8'h0, mem.regs[r]}, {8'h0, 8'hfa + 8'(r)});
        end
    endtask
    task automatic incDir();
        logic [7:0] a;
        for (int i = 0; i < 2; i++) begin
            a = 8'h37 + 8'(200 * i);
            mem.data[a] <= 8'hde + 8'(33 * i);
            run({OP_INC_DIR, a, 8'h0}, 2, progCounter + PC_STEP2, 0);
            chk({8'h0, mem.data[a]}, {8'h0, 8'hdf + 8'(33 * i)});
        end
    endtask
    task automatic bitBranches();
        logic [7:0] op [3];
        logic [7:0] off;
        logic [7:0] a;
        logic b;
        logic [15:0] e;
        op = '{OP_BRANCH_BIT_ONE, OP_BRANCH_BIT_ONE_AND_CLEAR, OP_BRANCH_BIT_ZERO};
        for (int i = 0; i < 6; i++) begin
            b = 1'(i % 2);
            off = 8'h7e + 8'(i);
            a = 8'h41 + 8'(i);
            mem.bits[a] <= b;
            e = progCounter + PC_STEP3;
            if ((i / 2 == 2) ? !b : b) e = e + {{8{off[7]}}, off};
            run({op[i / 2], a, off}, 3, e, i % 3);
            chk({15'h0, mem.bits[a]}, {15'h0, b & (i / 2 != 1)});
        end
    endtask
    task automatic carryBranches();
        logic [15:0] e;
        logic [7:0] op;
        for (int i = 0; i < 4; i++) begin
            carryFlag <= 1'(i % 2);
            op = (i < 2) ? OP_BRANCH_CARRY_ONE : OP_BRANCH_CARRY_ZERO;
            e = progCounter + PC_STEP2;
            if (1'(i % 2) ^ (i >= 2)) e = e - 16'h0033;
            run({op, 8'hcd, 8'h0}, 2, e, i);
        end
    endtask
    task automatic indirectJump();
        for (int i = 0; i < 2; i++) begin
            accum <= i ? 8'h20 : 8'h76;
            dataPointer16 <= i ? 16'hfff0 : 16'h02a8;
            run({OP_INDIRECT_JUMP, 16'h0}, 1, i ? 16'h0010 : 16'h031e, 0);
        end
    endtask
    // Opcode outside the subset: one byte taken, one flag pulse
    task automatic unknownOpcode();
        logic [15:0] p;
        int pulses;
        int takes;
        p = progCounter;
        pulses = 0;
        takes = 0;
        @(posedge ref_clk);
        mem.code[p] <= 8'h04;
        mem.loaded[p] <= 1'b1;
        repeat (4) begin
            @(negedge ref_clk);
            if (unknownOp === 1'b1) pulses++;
            if (codeTake === 1'b1) takes++;
        end
        @(posedge ref_clk);
        mem.loaded[p] <= 1'b0;
        chk(16'(pulses), 16'h0001);
        chk(16'(takes), 16'h0001);
        chk(progCounter, p + PC_STEP1);
    endtask
    // Reset while an operand is awaited, then a fresh branch from address zero
    task automatic resetMidRun();
        logic [15:0] p;
        p = progCounter;
        carryFlag <= 1'b1;
        @(posedge ref_clk);
        mem.code[p] <= OP_BRANCH_BIT_ONE;
        mem.loaded[p] <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b1;
        mem.loaded[p] <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk(progCounter, PC_RESET);
        run({OP_BRANCH_CARRY_ONE, 8'h10, 8'h0}, 2, PC_STEP2 + 16'h0010, 0);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        incRegAll();
        incDir();
        bitBranches();
        carryBranches();
        indirectJump();
        unknownOpcode();
        resetMidRun();
        tally_and_finish();
    end
    // Whole run needs about 260 cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        tally_and_finish();
    end
endmodule
